//--- hdl/cdc_pkg.sv
package cdc_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [2:0] OFS_CTRL   = 3'h0;
  localparam logic [2:0] OFS_MUX    = 3'h2;
  localparam logic [2:0] OFS_INTEN  = 3'h6;
  localparam logic [2:0] OFS_STATUS = 3'h7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_HYS_LSB    = 1;
  localparam int CTRL_LP_BIT     = 3;
  localparam int CTRL_EDGE_LSB   = 4;
  localparam int CTRL_PAD_BIT    = 6;
  localparam int CTRL_RUNSB_BIT  = 7;
  localparam int MUX_NEG_LSB     = 0;
  localparam int MUX_INV_BIT     = 7;
  localparam int INTEN_BIT       = 0;
  localparam int STAT_FLAG_BIT   = 0;
  localparam int STAT_STATE_BIT  = 4;

  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] MUX_RST   = 8'h00;
  localparam logic [7:0] MUX_MASK  = 8'h83;
  localparam logic [7:0] INTEN_RST = 8'h00;
  localparam int         SYNC_STAGES = 3;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] EDGE_EITHER  = 2'h0;
  localparam logic [1:0] EDGE_FALLING = 2'h2;
  localparam logic [1:0] EDGE_RISING  = 2'h3;
  localparam logic [1:0] NEG_PIN      = 2'h0;
  localparam logic [1:0] NEG_VREF     = 2'h2;
  localparam logic [1:0] NEG_CONV     = 2'h3;
  localparam logic [7:0] VECTOR_OFS   = 8'h00;

  typedef enum logic [2:0] {
    CDC_ACTIVE  = 3'b001,
    CDC_STANDBY = 3'b010,
    CDC_PDOWN   = 3'b100
  } cdc_sleep_e;

  // control lines toward the analog front end
  typedef struct packed {
    logic       enable;
    logic [1:0] hysteresis_select;
    logic       low_power_select;
    logic [1:0] negative_input_select;
  } cdc_afe_s;

endpackage

//--- hdl/cdc_comparator_ctrl.sv
// The strobed register port was left to the implementer.
module cdc_comparator_ctrl (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // register port
  input  wire logic [2:0]        addr,
  input  wire logic [7:0]        wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [7:0]        rdata,
  // sleep state from the power manager
  input  wire logic              sleep_idle,
  input  wire logic              sleep_standby,
  input  wire logic              sleep_pdown,
  input  wire logic              clk_per_requested,
  // analog front end
  input  wire logic              afe_result,
  output cdc_pkg::cdc_afe_s      afe_ctrl,
  // event and pad
  output logic                   event_out,
  output logic                   pad_out,
  output logic                   pad_oe,
  // interrupt
  output logic                   irq,
  output logic      [7:0]        irq_vector
);

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]                ctrl_r;
  logic [7:0]                mux_r;
  logic                      inten_r;
  logic                      flag_r;
  logic [7:0]                rdata_r;
  logic [cdc_pkg::SYNC_STAGES-1:0] sync_r;
  // agreed result, held while the last two stages differ
  logic                      held_r;
  logic                      prev_r;
  logic                      state_r;
  cdc_pkg::cdc_sleep_e       sleep_r;
  cdc_pkg::cdc_sleep_e       sleep_nxt;

  // ****************************************
  // field decode
  // ****************************************
  wire       en_bit     = ctrl_r[cdc_pkg::CTRL_ENABLE_BIT];
  wire [1:0] hys_sel    = ctrl_r[cdc_pkg::CTRL_HYS_LSB +: 2];
  wire       lp_sel     = ctrl_r[cdc_pkg::CTRL_LP_BIT];
  wire [1:0] edge_sel   = ctrl_r[cdc_pkg::CTRL_EDGE_LSB +: 2];
  wire       pad_en     = ctrl_r[cdc_pkg::CTRL_PAD_BIT];
  wire       run_sb     = ctrl_r[cdc_pkg::CTRL_RUNSB_BIT];
  wire [1:0] neg_sel    = mux_r[cdc_pkg::MUX_NEG_LSB +: 2];
  wire       invert     = mux_r[cdc_pkg::MUX_INV_BIT];
  // hysteresis and low power pass straight through to the front end

  // edge modes spelled out once so the hit logic reads plainly
  wire       mode_either  = (edge_sel == cdc_pkg::EDGE_EITHER);
  wire       mode_falling = (edge_sel == cdc_pkg::EDGE_FALLING);
  wire       mode_rising  = (edge_sel == cdc_pkg::EDGE_RISING);
  // code 1 matches none of these, so it raises no flag at all

  // ****************************************
  // sleep state
  // ****************************************
  // idle and debug leave the block as in active mode
  // pdown outranks standby when the power manager shows both;
  // idle needs no decode of its own
  always_comb
  begin
    unique case ({sleep_pdown, sleep_standby})
      2'b00: sleep_nxt = cdc_pkg::CDC_ACTIVE;
      2'b01: sleep_nxt = cdc_pkg::CDC_STANDBY;
      2'b10: sleep_nxt = cdc_pkg::CDC_PDOWN;
      2'b11: sleep_nxt = cdc_pkg::CDC_PDOWN;
    endcase
  end

  wire in_pdown   = (sleep_r == cdc_pkg::CDC_PDOWN);
  wire in_standby = (sleep_r == cdc_pkg::CDC_STANDBY);
  // in standby without run-in-standby the whole comparator halts;
  // with it, the front end and event keep going and only status
  // waits for someone to hold the peripheral clock
  // debug halt has no input here: the block simply keeps running

  // comparator runs unless powered down or halted in standby
  wire cmp_run    = en_bit && !in_pdown && (!in_standby || run_sb);
  // status only updates when the peripheral clock is really there
  wire stat_run   = cmp_run && (!in_standby || clk_per_requested);

  // ****************************************
  // result path
  // ****************************************
  wire neg_legal  = (neg_sel == cdc_pkg::NEG_PIN) || (neg_sel == cdc_pkg::NEG_VREF)
                    || (neg_sel == cdc_pkg::NEG_CONV);
  // a change counts only once the last two stages agree; until then
  // the held value stands, so a late settle cannot fake an edge
  wire sync_mid   = sync_r[cdc_pkg::SYNC_STAGES-2];
  wire sync_last  = sync_r[cdc_pkg::SYNC_STAGES-1];
  wire sync_agree = (sync_mid == sync_last);
  wire sync_q     = sync_agree ? sync_last : held_r;
  wire res_fix    = sync_q ^ invert;

  // a reserved negative code leaves the front end off, so nothing
  // it shows may reach the event or the pad
  wire run_ok     = cmp_run && neg_legal;

  // ****************************************
  // edge detection
  // ****************************************
  wire rise       = res_fix && !prev_r;
  wire fall       = !res_fix && prev_r;
  wire hit_either = mode_either && (rise || fall);
  wire hit_fall   = mode_falling && fall;
  wire hit_rise   = mode_rising && rise;
  wire edge_hit   = hit_either || hit_fall || hit_rise;
  // limitation: an edge seen while status is frozen is lost for good
  wire edge_take  = edge_hit && stat_run;

  // ****************************************
  // register port decode
  // ****************************************
  // writes to the gaps between registers fall through every decode
  // and are dropped; in the status word only the flag is writable
  wire wr_ctrl    = wr && (addr == cdc_pkg::OFS_CTRL);
  wire wr_mux     = wr && (addr == cdc_pkg::OFS_MUX);
  wire wr_inten   = wr && (addr == cdc_pkg::OFS_INTEN);
  wire clr_flag   = wr && (addr == cdc_pkg::OFS_STATUS)
                    && wdata[cdc_pkg::STAT_FLAG_BIT];
  wire flag_nxt   = edge_take || (flag_r && !clr_flag);


  // status word: state in bit four, flag in bit zero
  wire [7:0] stat_word = {3'h0, state_r, 3'h0, flag_r};
  // unmapped offsets read as zero
  wire [7:0] rd_ctrl   = (addr == cdc_pkg::OFS_CTRL)   ? ctrl_r : 8'h00;
  wire [7:0] rd_mux    = (addr == cdc_pkg::OFS_MUX)    ? mux_r : 8'h00;
  wire [7:0] rd_inten  = (addr == cdc_pkg::OFS_INTEN)  ? {7'h00, inten_r} : 8'h00;
  wire [7:0] rd_stat   = (addr == cdc_pkg::OFS_STATUS) ? stat_word : 8'h00;
  wire [7:0] rd_word   = rd_ctrl | rd_mux | rd_inten | rd_stat;

  // ****************************************
  // synchroniser
  // ****************************************
  // front-end result is asynchronous to clk; stage count fixed by
  // the lag the state bit must show
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sync_r <= '0;
    else
      sync_r <= {sync_r[cdc_pkg::SYNC_STAGES-2:0], afe_result};
  end

  // holds the last agreed value while the stages disagree;
  // resets to the idle level of the result so no edge follows reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      held_r <= 1'b0;
    else
      held_r <= sync_q;
  end

  // ****************************************
  // edge history and state bit
  // ****************************************
  // prev tracks even when frozen, so no stale edge shows on wake
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      prev_r <= 1'b0;
    else
      prev_r <= res_fix;
  end

  // state freezes while status is not being updated
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      state_r <= 1'b0;
    else if (stat_run)
      state_r <= res_fix;
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      ctrl_r <= cdc_pkg::CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= wdata;
  end

  // gap bits are never stored, so they always read zero;
  // invert applies to every consumer downstream
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      mux_r <= cdc_pkg::MUX_RST;
    else if (wr_mux)
      mux_r <= wdata & cdc_pkg::MUX_MASK;
  end

  // one bit, the rest of the word is ignored
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      inten_r <= cdc_pkg::INTEN_RST[0];
    else if (wr_inten)
      inten_r <= wdata[cdc_pkg::INTEN_BIT];
  end

  // an edge in the same cycle as a clear wins, so none is lost;
  // clear only ever comes from a one written to bit zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  // sleep inputs act one cycle after they change
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      sleep_r <= cdc_pkg::CDC_ACTIVE;
    else
      sleep_r <= sleep_nxt;
  end

  // ****************************************
  // read port
  // ****************************************
  // data stand one cycle after the strobe and are zero otherwise,
  // so a bus that ors several slaves needs no extra gating
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata_r <= 8'h00;
    else if (rd)
      rdata_r <= rd_word;
    else
      rdata_r <= 8'h00;
  end
  assign rdata = rdata_r;

  // ****************************************
  // outputs
  // ****************************************
  // front-end controls are registered so the analog side sees no glitch;
  // reserved negative code keeps the front end off
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      afe_ctrl <= '0;
    else
    begin
      afe_ctrl.enable                <= run_ok;
      afe_ctrl.hysteresis_select     <= hys_sel;
      afe_ctrl.low_power_select      <= lp_sel;
      afe_ctrl.negative_input_select <= neg_sel;
    end
  end

  // ****************************************
  // event and pad
  // ****************************************
  // the event needs no setup beyond the enable bit
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      event_out <= 1'b0;
    else
      event_out <= run_ok && res_fix;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pad_out <= 1'b0;
    else
      pad_out <= run_ok && pad_en && res_fix;
  end

  // pad released in power-down whatever the enable bits say
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      pad_oe <= 1'b0;
    else
      pad_oe <= cmp_run && pad_en;
  end

  // ****************************************
  // interrupt
  // ****************************************
  // built from flag_nxt so the request rises with the flag, not after
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= inten_r && flag_nxt;
  end

  // one source, so the vector never moves; kept in a flop so every
  // output leaves the block from a register
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq_vector <= cdc_pkg::VECTOR_OFS;
    else
      irq_vector <= cdc_pkg::VECTOR_OFS;
  end

endmodule

//--- bench/cdc_checker.sv
module cdc_checker (
  // clock, reset, registers
  input wire logic       clk, rst_b, wr, rd,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata, rdata, irq_vector,
  // sleep, front end, outputs
  input wire logic       sleep_idle, sleep_standby, sleep_pdown, clk_per_requested,
  input wire logic       afe_result, event_out, pad_out, pad_oe, irq,
  input cdc_pkg::cdc_afe_s afe_ctrl
);
  // ************
  // port checks
  // ************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_vector_zero: assert property (irq_vector == 8'h00) else $error("vector not zero");
  chk_irq_release:
    assert property ($fell(irq) |-> $past(wr) && $past(addr) == 3'h7 && $past(wdata[0])
      || $past(sleep_standby) || $past(sleep_pdown) || $past(wr, 2) && $past(addr, 2) == 3'h6
      || $past(wr) && $past(addr) == 3'h6) else $error("irq fell without cause");
  chk_irq_mask:
    assert property (wr && addr == 3'h6 && !wdata[0] |-> ##2 !irq) else $error("irq unmasked");
  chk_pdown_off:
    assert property (sleep_pdown [*3] |-> !pad_oe && !afe_ctrl.enable) else $error("pdown on");
  chk_event_off:
    assert property (!afe_ctrl.enable [*3] |-> !event_out) else $error("event while off");
  chk_pad_match:
    assert property (pad_oe |-> pad_out == event_out) else $error("pad differs from event");
  chk_rdata_idle:
    assert property (!$past(rd) |-> rdata == 8'h00) else $error("rdata without read");
  chk_mux_read:
    assert property (rd && addr == 3'h2 |=> rdata[6:2] == 5'h00) else $error("mux gap bits");
  cover property ($rose(irq));
  cover property (sleep_standby && event_out);
  cover property (pad_oe && $rose(pad_out));
endmodule
bind cdc_comparator_ctrl cdc_checker i_cdc_checker (.clk, .rst_b, .addr, .wdata, .wr, .rd,
  .rdata, .sleep_idle, .sleep_standby, .sleep_pdown, .clk_per_requested, .afe_result,
  .afe_ctrl, .event_out, .pad_out, .pad_oe, .irq, .irq_vector);

//--- bench/cdc_afe_model.sv
module cdc_afe_model (
  // control in, result out
  input cdc_pkg::cdc_afe_s afe_ctrl,
  input wire logic         level,
  output logic             afe_result
);
  timeunit 1ns;
  timeprecision 1ns;
  // low power answers later; switched off it decides nothing
  always @(afe_ctrl or level)
    afe_result <= #(afe_ctrl.low_power_select ? 37 : 9) afe_ctrl.enable && level;
endmodule

//--- bench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %0h got %0h", n, e, g); end end
  logic clk = '0, rst_b = '0, wr = '0, rd = '0, level = '0, sleep_idle = '0;
  logic sleep_standby = '0, sleep_pdown = '0, clk_per_requested = '0, lv;
  logic [2:0] addr = '0;
  logic [7:0] wdata = '0, rdata, irq_vector, c;
  logic [1:0] m;
  logic afe_result, event_out, pad_out, pad_oe, irq;
  cdc_pkg::cdc_afe_s afe_ctrl;
  int n_fail = 0, samples_checked = 0;
  always #50 clk = ~clk;
  cdc_comparator_ctrl i_cdc_comparator_ctrl (.clk, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
    .sleep_idle, .sleep_standby, .sleep_pdown, .clk_per_requested, .afe_result, .afe_ctrl,
    .event_out, .pad_out, .pad_oe, .irq, .irq_vector);
  cdc_afe_model i_cdc_afe_model (.afe_ctrl, .level, .afe_result);
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk);
    {wr, rd} <= 2'h0;
    if (!w) #1 `CHK("rdata", d, rdata)
  endtask
  function automatic logic exp_irq(logic [1:0] md, logic up);
    return md == cdc_pkg::EDGE_EITHER || md == (up ? cdc_pkg::EDGE_RISING : cdc_pkg::EDGE_FALLING);
  endfunction
  task automatic finish_test;
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    n_fail++;
    finish_test;
  end
  initial
  begin
    void'($urandom(61820));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) bus(1'b0, a[2:0], 8'h00);
    bus(1'b1, 3'h2, 8'hFF);
    bus(1'b0, 3'h2, cdc_pkg::MUX_MASK);
    repeat (6)
    begin
      c = 8'($urandom) | 8'h01;
      m = {c[7], c[7] & c[6]};
      bus(1'b1, 3'h2, {6'h00, m});
      bus(1'b1, 3'h0, c);
      bus(1'b0, 3'h0, c);
      `CHK("afe", {1'b1, c[2:1], c[3], m}, afe_ctrl)
    end
    bus(1'b1, 3'h2, 8'h01);
    bus(1'b0, 3'h2, 8'h01);
    `CHK("afe off", 1'b0, afe_ctrl.enable)
    sleep_idle <= 1'b1;
    bus(1'b1, 3'h6, 8'h01);
    for (int i = 0; i < 8; i++)
    begin
      m = i[1:0];
      level = 1'b0;
      bus(1'b1, 3'h2, {i[2], 7'h00});
      bus(1'b1, 3'h0, {2'h1, m, 4'h1});
      repeat (30) @(posedge clk);
      bus(1'b1, 3'h7, 8'h01);
      for (int r = 1; r >= 0; r--)
      begin
        level = r[0];
        lv = r[0] ^ i[2];
        #850;
        `CHK("outs", {lv, lv, 1'b1}, {event_out, pad_out, pad_oe})
        `CHK("irq", exp_irq(m, lv), irq)
        bus(1'b1, 3'h7, 8'h00);
        bus(1'b0, 3'h7, {3'h0, lv, 3'h0, exp_irq(m, lv)});
        bus(1'b1, 3'h7, 8'h01);
      end
    end
    bus(1'b1, 3'h0, 8'hC1);
    bus(1'b1, 3'h6, 8'h00);
    level = 1'b1;
    #850;
    `CHK("masked", 1'b0, irq)
    bus(1'b1, 3'h6, 8'h01);
    bus(1'b0, 3'h7, 8'h01);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, 3'h7, 8'h01);
    sleep_standby <= 1'b1;
    #850;
    level = 1'b0;
    #850;
    `CHK("standby", 4'hE, {event_out, pad_out, pad_oe, irq})
    bus(1'b0, 3'h7, 8'h00);
    clk_per_requested <= 1'b1;
    level = 1'b1;
    #850;
    `CHK("standby clk", 2'h3, {irq, pad_oe})
    sleep_pdown <= 1'b1;
    #850;
    `CHK("pdown", 2'h0, {pad_oe, afe_ctrl.enable})
    finish_test;
  end
endmodule
